// *** src/pcfd_pkg.sv ***
// Constants shared by the pulse capture timer and its prescaler.
// Assumes a single 40 MHz clock domain and an 8-bit register port.
package pcfd_pkg;
    // ==========================================
    // Register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CNT = 4'h1;
    localparam logic [3:0] ADDR_INTC = 4'h2;
    localparam logic [3:0] ADDR_MISC = 4'h3;
    // ==========================================
    // Field positions
    localparam int CTL_MODE_LSB = 6;
    localparam int CTL_ON = 4;
    localparam int CTL_EDGE = 3;
    localparam int INTC_EN = 0;
    localparam int INTC_FLAG = 1;
    localparam int MISC_PFD_EN = 0;
    localparam int MISC_OD_LSB = 4;
    // ==========================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h08;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] PRELOAD_RST = 8'h00;
    localparam logic [7:0] INTC_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [7:0] CNT_FULL = 8'hff;
    // ==========================================
    // Modes and states
    localparam logic [1:0] MODE_EVT_CMP = 2'b00;
    localparam logic [1:0] MODE_EVT_PIN = 2'b01;
    localparam logic [1:0] MODE_TIMER = 2'b10;
    localparam logic [1:0] MODE_CAPTURE = 2'b11;
    localparam int PSC_W = 7;
    localparam int SYNC_N = 4;
    typedef enum logic [1:0] {
        CAP_IDLE = 2'b00,
        CAP_ARMED = 2'b01,
        CAP_RUN = 2'b11
    } pcfd_cap_t;
endpackage

// *** src/pcfd_pre_if.sv ***
// Link between the timer core and its clock prescaler.
// Assumes both ends share the same clock.
`timescale 1ns/100ps
`default_nettype none
interface pcfd_pre_if;
    logic [2:0] psc;
    logic hold;
    logic tick;
    modport ctl (output psc, output hold, input tick);
    modport pre (input psc, input hold, output tick);
endinterface
`default_nettype wire

// *** src/pcfd_prescaler.sv ***
// Prescaler: one-cycle tick every 2**psc system clocks.
// Assumes psc and hold come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pcfd_prescaler (
    input wire logic clk, // System clock
    input wire logic arst_n, // Async reset
    pcfd_pre_if.pre pre // Rate in, tick out
);
    logic [pcfd_pkg::PSC_W-1:0] div_r;
    logic [pcfd_pkg::PSC_W-1:0] div_nxt;
    logic [pcfd_pkg::PSC_W-1:0] mask;

    always_comb begin
        div_nxt = div_r + 7'h01;
        mask = 7'(({7'h00, 1'b1} << pre.psc) - 8'h01);
    end

    // Held tick is dropped, so a count may be lost
    assign pre.tick = !pre.hold && ((div_r & mask) == mask);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= 7'h00;
        end else begin
            div_r <= div_nxt;
        end
    end
endmodule
`default_nettype wire

// *** src/pcfd_top.sv ***
// Eight-bit count-up timer with pulse width capture and divider output.
// Assumes one 40 MHz clock; pins arrive asynchronously and are synced.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pcfd_top (
    input wire logic clk, // 40 MHz system clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [3:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd
    input wire logic timer_pin, // Shared timer input pin
    input wire logic cmp_out, // Comparator output for event mode
    input wire logic [1:0] ext_int_pin, // External interrupt pins
    output logic [1:0] ext_int_filt, // Filtered interrupt pins
    input wire logic filter_on, // Pin filter option
    input wire logic power_down, // Core is powered down
    output logic irq, // Timer interrupt to core
    output logic wake, // Wake-up pulse
    output logic shared_divider_pin_out, // Divider pin level
    output logic shared_divider_pin_oe, // Divider drives pin
    output logic [3:0] open_drain_sel // Port B open drain selects
);
    // ==========================================
    // Declarations
    logic [pcfd_pkg::SYNC_N-1:0] raw;
    logic [pcfd_pkg::SYNC_N-1:0] s1_r;
    logic [pcfd_pkg::SYNC_N-1:0] s2_r;
    logic [pcfd_pkg::SYNC_N-1:0] s3_r;
    logic [pcfd_pkg::SYNC_N-1:0] flt_r;
    logic [pcfd_pkg::SYNC_N-1:0] flt_nxt;
    logic [pcfd_pkg::SYNC_N-1:0] prev_r;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] preload_r;
    logic [7:0] preload_nxt;
    logic ien_r;
    logic ien_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [7:0] misc_r;
    logic [7:0] misc_nxt;
    logic pfd_r;
    logic pfd_nxt;
    logic wake_r;
    logic wake_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    pcfd_pkg::pcfd_cap_t cap_r;
    pcfd_pkg::pcfd_cap_t cap_nxt;
    logic [1:0] mode;
    logic count_enable_bit;
    logic te;
    logic cap_mode;
    logic pin_rise;
    logic pin_fall;
    logic cmp_rise;
    logic cmp_fall;
    logic start_edge;
    logic stop_edge;
    logic auto_clr;
    logic step;
    logic ovf;
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_intc;
    logic wr_misc;
    logic rd_cnt;
    logic tick;

    pcfd_pre_if pre_bus ();

    // ==========================================
    // Pin synchronisers and shared filter
    assign raw = {cmp_out, ext_int_pin, timer_pin};

    genvar gi;
    generate
        for (gi = 0; gi < pcfd_pkg::SYNC_N; gi++) begin : g_pin
            // Comparator is internal and skips the pin filter
            always_comb begin
                if (!(filter_on && gi < 3) || s2_r[gi] == s3_r[gi]) begin
                    flt_nxt[gi] = s2_r[gi];
                end else begin
                    flt_nxt[gi] = flt_r[gi];
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    flt_r[gi] <= 1'b0;
                    prev_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    flt_r[gi] <= flt_nxt[gi];
                    prev_r[gi] <= flt_r[gi];
                end
            end
        end
    endgenerate

    assign ext_int_filt = flt_r[2:1];

    // ==========================================
    // Edge detection
    always_comb begin
        pin_rise = flt_r[0] && !prev_r[0];
        pin_fall = !flt_r[0] && prev_r[0];
        cmp_rise = flt_r[3] && !prev_r[3];
        cmp_fall = !flt_r[3] && prev_r[3];
        start_edge = te ? pin_rise : pin_fall;
        stop_edge = te ? pin_fall : pin_rise;
    end

    // ==========================================
    // Register decode
    always_comb begin
        mode = ctrl_r[pcfd_pkg::CTL_MODE_LSB +: 2];
        count_enable_bit = ctrl_r[pcfd_pkg::CTL_ON];
        te = ctrl_r[pcfd_pkg::CTL_EDGE];
        cap_mode = (mode == pcfd_pkg::MODE_CAPTURE);
        wr_ctrl = wr && addr == pcfd_pkg::ADDR_CTRL;
        wr_cnt = wr && addr == pcfd_pkg::ADDR_CNT;
        wr_intc = wr && addr == pcfd_pkg::ADDR_INTC;
        wr_misc = wr && addr == pcfd_pkg::ADDR_MISC;
        rd_cnt = rd && addr == pcfd_pkg::ADDR_CNT;
    end

    // ==========================================
    // Prescaler
    assign pre_bus.psc = ctrl_r[2:0];
    assign pre_bus.hold = rd_cnt || wr_cnt;
    assign tick = pre_bus.tick;

    pcfd_prescaler u_pre (
        .clk(clk),
        .arst_n(arst_n),
        .pre(pre_bus)
    );

    // ==========================================
    // Capture sequencer
    always_comb begin
        cap_nxt = cap_r;
        auto_clr = 1'b0;
        case (cap_r)
            pcfd_pkg::CAP_IDLE: begin
                if (cap_mode && count_enable_bit) begin
                    cap_nxt = pcfd_pkg::CAP_ARMED;
                end
            end
            pcfd_pkg::CAP_ARMED: begin
                if (!cap_mode || !count_enable_bit) begin
                    cap_nxt = pcfd_pkg::CAP_IDLE;
                end else if (start_edge) begin
                    cap_nxt = pcfd_pkg::CAP_RUN;
                end
            end
            pcfd_pkg::CAP_RUN: begin
                if (!cap_mode || !count_enable_bit) begin
                    cap_nxt = pcfd_pkg::CAP_IDLE;
                end else if (stop_edge) begin
                    cap_nxt = pcfd_pkg::CAP_IDLE;
                    auto_clr = 1'b1;
                end
            end
            default: begin
                cap_nxt = pcfd_pkg::CAP_IDLE;
            end
        endcase
    end

    // ==========================================
    // Counter, preload and divider
    always_comb begin
        step = 1'b0;
        case (mode)
            pcfd_pkg::MODE_CAPTURE: step = (cap_r == pcfd_pkg::CAP_RUN) && tick;
            pcfd_pkg::MODE_TIMER: step = count_enable_bit && tick;
            pcfd_pkg::MODE_EVT_PIN: step = count_enable_bit && !pre_bus.hold && (te ? pin_fall : pin_rise);
            default: step = count_enable_bit && !pre_bus.hold && (te ? cmp_fall : cmp_rise);
        endcase
        ovf = step && cnt_r == pcfd_pkg::CNT_FULL;
        preload_nxt = wr_cnt ? wdata : preload_r;
        if (ovf) begin
            cnt_nxt = preload_r;
        end else if (step) begin
            cnt_nxt = cnt_r + 8'h01;
        end else if (wr_cnt && !count_enable_bit) begin
            // Stopped timer loads the count directly
            cnt_nxt = wdata;
        end else begin
            cnt_nxt = cnt_r;
        end
        pfd_nxt = ovf ? !pfd_r : pfd_r;
    end

    // ==========================================
    // Control, interrupt and misc registers
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = {wdata[7:6], 1'b0, wdata[4:0]};
        end else if (auto_clr) begin
            ctrl_nxt[pcfd_pkg::CTL_ON] = 1'b0;
        end
        ien_nxt = wr_intc ? wdata[pcfd_pkg::INTC_EN] : ien_r;
        // Overflow beats a same-cycle clear
        if (ovf) begin
            flag_nxt = 1'b1;
        end else if (wr_intc) begin
            flag_nxt = wdata[pcfd_pkg::INTC_FLAG];
        end else begin
            flag_nxt = flag_r;
        end
        // A flag already set blocks the wake-up
        wake_nxt = ovf && power_down && !flag_r;
        misc_nxt = wr_misc ? {wdata[7:4], 3'b000, wdata[0]} : misc_r;
    end

    // ==========================================
    // Read port
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd) begin
            case (addr)
                pcfd_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
                pcfd_pkg::ADDR_CNT: rdata_nxt = cnt_r;
                pcfd_pkg::ADDR_INTC: rdata_nxt = {6'h00, flag_r, ien_r};
                pcfd_pkg::ADDR_MISC: rdata_nxt = misc_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // ==========================================
    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= pcfd_pkg::CTRL_RST;
            cnt_r <= pcfd_pkg::CNT_RST;
            preload_r <= pcfd_pkg::PRELOAD_RST;
            ien_r <= pcfd_pkg::INTC_RST[pcfd_pkg::INTC_EN];
            flag_r <= pcfd_pkg::INTC_RST[pcfd_pkg::INTC_FLAG];
            misc_r <= pcfd_pkg::MISC_RST;
            pfd_r <= 1'b0;
            wake_r <= 1'b0;
            rdata_r <= 8'h00;
            cap_r <= pcfd_pkg::CAP_IDLE;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            preload_r <= preload_nxt;
            ien_r <= ien_nxt;
            flag_r <= flag_nxt;
            misc_r <= misc_nxt;
            pfd_r <= pfd_nxt;
            wake_r <= wake_nxt;
            rdata_r <= rdata_nxt;
            cap_r <= cap_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign rdata = rdata_r;
    assign irq = flag_r && ien_r;
    assign wake = wake_r;
    assign shared_divider_pin_out = pfd_r;
    assign shared_divider_pin_oe = misc_r[pcfd_pkg::MISC_PFD_EN];
    assign open_drain_sel = misc_r[pcfd_pkg::MISC_OD_LSB +: 4];
endmodule
`default_nettype wire

// *** test/pcfd_pulse_src.sv ***
// Pulse source standing on the shared timer pin.
// Assumes go is a one-cycle strobe driven on the clk rising edge.
`timescale 1ns/100ps
`default_nettype none
module pcfd_pulse_src (
    input wire logic clk, // System clock
    input wire logic go, // Start one pulse
    input wire logic pol, // Active pulse level
    input wire logic [7:0] width, // Pulse length in clocks
    output logic pin // Timer pin drive
);
    logic busy = 1'b0;
    initial pin = 1'b0;
    // Idle level tracks polarity, so only a pulse makes a start edge
    always @(pol) if (!busy) pin = ~pol;
    // Edges land mid-cycle, 7 ns after a rising edge of the timer clock
    always @(posedge clk) begin
        if (go) begin
            busy = 1'b1;
            #7 pin = pol;
            repeat (width) @(posedge clk);
            #7 pin = ~pol;
            busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** test/pcfd_chk.sv ***
// Port checker for pcfd_top.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module pcfd_chk (
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic [3:0] addr, // Address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [7:0] rdata, // Read data
    input wire logic [1:0] ext_int_pin, // Raw pins
    input wire logic [1:0] ext_int_filt, // Filtered pins
    input wire logic power_down, // Powered down
    input wire logic irq, // Interrupt
    input wire logic wake, // Wake pulse
    input wire logic shared_divider_pin_oe, // Divider drive
    input wire logic [3:0] open_drain_sel // Open drain selects
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic wm = wr && addr == pcfd_pkg::ADDR_MISC;
    wire logic wi = wr && addr == pcfd_pkg::ADDR_INTC;
    property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_mres; $past(rd) && $past(addr) == pcfd_pkg::ADDR_MISC |-> rdata[3:1] == 3'h0; endproperty
    a_mres: assert property (p_mres) else $error("misc reserved bits set");
    property p_oe; wm |=> shared_divider_pin_oe == $past(wdata[0]); endproperty
    a_oe: assert property (p_oe) else $error("divider enable wrong");
    property p_oest; !wm |=> $stable(shared_divider_pin_oe); endproperty
    a_oest: assert property (p_oest) else $error("divider enable moved");
    property p_od; wm |=> open_drain_sel == $past(wdata[7:4]); endproperty
    a_od: assert property (p_od) else $error("open drain selects wrong");
    property p_irqon; wi && wdata[1:0] == 2'b11 |-> ##2 irq; endproperty
    a_irqon: assert property (p_irqon) else $error("irq missing");
    property p_irqoff; wi && !wdata[0] |-> ##2 !irq; endproperty
    a_irqoff: assert property (p_irqoff) else $error("masked irq seen");
    property p_wkpd; wake |-> $past(power_down); endproperty
    a_wkpd: assert property (p_wkpd) else $error("wake while running");
    property p_wk1; wake |=> !wake; endproperty
    a_wk1: assert property (p_wk1) else $error("wake too long");
    property p_filt; $stable(ext_int_pin) [*8] |-> ext_int_filt == ext_int_pin; endproperty
    a_filt: assert property (p_filt) else $error("filtered pin lags");
endmodule
bind pcfd_top pcfd_chk chk_u (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .ext_int_pin,
    .ext_int_filt, .power_down, .irq, .wake, .shared_divider_pin_oe, .open_drain_sel);
`default_nettype wire

// *** test/pcfd_top_tb.sv ***
// Self-checking bench for pcfd_top with a pulse source on the timer pin.
// Assumes a 40 MHz clock and one-cycle register strobes.
`timescale 1ns/100ps
`default_nettype none
module pcfd_top_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic filt_on = 1'b0;
    logic pd = 1'b0;
    logic go = 1'b0;
    logic pol = 1'b1;
    logic [7:0] pw = 8'h00;
    logic [1:0] ext_in = 2'h0;
    logic [7:0] seed = 8'h5c;
    logic [7:0] es = 8'h5c;
    logic [3:0] tk = 4'h0;
    logic [7:0] rdata, c, w;
    logic [3:0] ods;
    logic [1:0] ext_f;
    logic tpin, irq, wake, pout, poe, po;
    int bad_count = 0;
    int n_checks = 0;
    int wakes = 0;
    always #12.5 clk = ~clk;
    pcfd_top dut_u (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_pin(tpin), .cmp_out(1'b0), .ext_int_pin(ext_in),
        .ext_int_filt(ext_f), .filter_on(filt_on), .power_down(pd), .irq(irq), .wake(wake),
        .shared_divider_pin_out(pout), .shared_divider_pin_oe(poe), .open_drain_sel(ods));
    pcfd_pulse_src src_u (.clk(clk), .go(go), .pol(pol), .width(pw), .pin(tpin));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Sync delay lets a width land one timer clock either side
    function automatic logic [7:0] near(input logic [7:0] s, input logic [7:0] e);
        return (s == e || s - e == 8'h01 || e - s == 8'h01) ? 8'h01 : 8'h00;
    endfunction
    always @(posedge clk) begin
        tk <= tk + 4'h1;
        if (tk == 4'h0) begin
            es <= lfsr(es);
            ext_in <= es[1:0];
        end
        if (wake === 1'b1) wakes <= wakes + 1;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Data stand only in the cycle after the strobe; take them at its end
        @(posedge clk);
        d = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        check(v, e);
    endtask
    task automatic pulse(input logic [7:0] len);
        int k;
        pw <= len;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        for (k = 0; tpin !== ~pol; k++) begin
            if (k == 300) begin
                bad_count++;
                final_report();
            end
            @(posedge clk);
        end
    endtask
    // One armed capture; the frozen count comes back in cnt
    task automatic measure(input logic te, input logic [2:0] p, input logic [7:0] pre,
        input logic [7:0] len, output logic [7:0] cnt);
        logic [7:0] v;
        int k;
        pol <= te;
        repeat (8) @(posedge clk);
        wr_reg(pcfd_pkg::ADDR_CNT, pre);
        wr_reg(pcfd_pkg::ADDR_CTRL, {4'hc, te, p});
        wr_reg(pcfd_pkg::ADDR_CTRL, {4'hd, te, p});
        repeat (10) @(posedge clk);
        rd_chk(pcfd_pkg::ADDR_CNT, pre);
        pulse(len);
        for (k = 0; k < 400; k++) begin
            rd_reg(pcfd_pkg::ADDR_CTRL, v);
            if (v[pcfd_pkg::CTL_ON] === 1'b0) break;
        end
        if (k == 400) begin
            bad_count++;
            final_report();
        end
        rd_reg(pcfd_pkg::ADDR_CNT, cnt);
    endtask
    initial begin
        #2500000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(pcfd_pkg::ADDR_CTRL, pcfd_pkg::CTRL_RST);
        rd_chk(pcfd_pkg::ADDR_CNT, pcfd_pkg::CNT_RST);
        rd_chk(pcfd_pkg::ADDR_INTC, pcfd_pkg::INTC_RST);
        rd_chk(pcfd_pkg::ADDR_MISC, pcfd_pkg::MISC_RST);
        rd_chk(4'h9, 8'h00);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            wr_reg(pcfd_pkg::ADDR_MISC, i == 4 ? 8'h01 : seed);
            rd_chk(pcfd_pkg::ADDR_MISC, i == 4 ? 8'h01 : {seed[7:4], 3'h0, seed[0]});
            check({4'h0, ods}, i == 4 ? 8'h00 : {4'h0, seed[7:4]});
        end
        check({7'h0, poe}, 8'h01);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            filt_on <= (i >= 4);
            w = 8'h14 + {2'h0, seed[5:0]};
            measure(i[0], {1'b0, seed[7:6]}, 8'h00, w, c);
            check(near(c, w >> seed[7:6]), 8'h01);
            pulse(w);
            rd_chk(pcfd_pkg::ADDR_CNT, c);
        end
        filt_on <= 1'b0;
        wr_reg(pcfd_pkg::ADDR_INTC, 8'h03);
        repeat (2) @(posedge clk);
        check({7'h0, irq}, 8'h01);
        wr_reg(pcfd_pkg::ADDR_INTC, 8'h01);
        pd <= 1'b1;
        po = pout;
        measure(1'b1, 3'h0, 8'hf0, 8'h14, c);
        check(near(c, 8'hf4), 8'h01);
        check({7'h0, pout}, {7'h0, ~po});
        check({7'h0, irq}, 8'h01);
        check(8'(wakes), 8'h01);
        rd_chk(pcfd_pkg::ADDR_INTC, 8'h03);
        wr_reg(pcfd_pkg::ADDR_INTC, 8'h02);
        measure(1'b1, 3'h0, 8'hf0, 8'h14, c);
        check({7'h0, irq}, 8'h00);
        check(8'(wakes), 8'h01);
        pd <= 1'b0;
        // Event pin mode: rising pin edges count, enable stays set
        wr_reg(pcfd_pkg::ADDR_CNT, 8'h10);
        wr_reg(pcfd_pkg::ADDR_CTRL, 8'h40);
        wr_reg(pcfd_pkg::ADDR_CTRL, 8'h50);
        pulse(8'h20);
        repeat (8) @(posedge clk);
        rd_chk(pcfd_pkg::ADDR_CTRL, 8'h50);
        rd_chk(pcfd_pkg::ADDR_CNT, 8'h11);
        // Timer mode at full rate: each counter read costs one tick
        wr_reg(pcfd_pkg::ADDR_CTRL, 8'h80);
        wr_reg(pcfd_pkg::ADDR_CNT, 8'h00);
        wr_reg(pcfd_pkg::ADDR_CTRL, 8'h90);
        rd_chk(pcfd_pkg::ADDR_CNT, 8'h01);
        rd_chk(pcfd_pkg::ADDR_CNT, 8'h03);
        final_report();
    end
endmodule
`default_nettype wire
